// >>> design/switch_timing_pkg.sv
package switch_timing_pkg;

	// ==========================================================
	// register map
	localparam logic [13:0] MAIN_CONTROL_ADDR  = 14'h0000;
	localparam logic [15:0] MAIN_CONTROL_RESET = 16'h0000;
	localparam logic [15:0] MAIN_CONTROL_MASK  = 16'h3FFF;

	// ==========================================================
	// field positions of main_control
	localparam int SLAVE_LOOP_ENABLE_BIT = 13;
	localparam int OPERATION_HI          = 12;
	localparam int OPERATION_LO          = 11;
	localparam int LOOPBACK_BIT          = 10;
	localparam int FP_POSITION_BIT       = 9;
	localparam int CLOCK_POLARITY_BIT    = 8;
	localparam int FP_POLARITY_BIT       = 7;
	localparam int RATE_HI               = 6;
	localparam int RATE_LO               = 5;

	// ==========================================================
	// encodings
	localparam logic [1:0] OPERATION_MASTER = 2'h0;
	localparam logic [1:0] RATE_16M         = 2'h0;
	localparam logic [1:0] RATE_8M          = 2'h1;
	localparam logic [1:0] RATE_4M          = 2'h2;
	localparam logic [1:0] RATE_RESERVED    = 2'h3;

	// ==========================================================
	// timing: frame pulse widths, converted at the system clock rate
	localparam int CLOCK_MHZ           = 40;
	localparam int LOOPBACK_CLOCK_KHZ  = 16384;
	localparam int FP_WIDTH_16M_NS     = 61;
	localparam int FP_WIDTH_8M_NS      = 122;
	localparam int FP_WIDTH_4M_NS      = 244;
	localparam logic [3:0] FP_WIDTH_16M_CYCLES = 4'((FP_WIDTH_16M_NS * CLOCK_MHZ + 999) / 1000);
	localparam logic [3:0] FP_WIDTH_8M_CYCLES  = 4'((FP_WIDTH_8M_NS * CLOCK_MHZ + 999) / 1000);
	localparam logic [3:0] FP_WIDTH_4M_CYCLES  = 4'((FP_WIDTH_4M_NS * CLOCK_MHZ + 999) / 1000);

	// ==========================================================
	// decoded configuration handed to the timing logic
	typedef struct packed {
		logic       slave_mode;
		logic       loop_enable;
		logic       low_from_input;
		logic       high_locked_ref;
		logic       ref_fail_drive;
		logic       loopback_active;
		logic       fp_starts_at_boundary;
		logic       rising_edge_aligned;
		logic       fp_active_high;
		logic [1:0] rate;
		logic       rate_reserved;
		logic       loopback_rate_conflict;
		logic [3:0] fp_width_cycles;
	} timing_config_t;

endpackage : switch_timing_pkg

// >>> design/frame_boundary_detect.sv
`timescale 1ns/1ps
`default_nettype none

module frame_boundary_detect (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic input_clock,
	input  wire logic input_frame_pulse,
	input  wire logic rising_edge_aligned,
	input  wire logic fp_active_high,
	input  wire logic fp_starts_at_boundary,
	output logic      frame_boundary,
	output logic      frame_pulse_active
);

	typedef struct packed {
		logic clock_q;
		logic active_q;
		logic boundary;
	} detect_state_t;

	detect_state_t state;
	detect_state_t next_state;
	logic          aligned_edge;
	logic          active_now;

	// ==========================================================
	// edge and pulse qualification
	always_comb begin
		next_state = state;
		aligned_edge = rising_edge_aligned ? (input_clock & ~state.clock_q) : (~input_clock & state.clock_q);
		active_now = fp_active_high ? input_frame_pulse : ~input_frame_pulse;
		next_state.clock_q  = input_clock;
		next_state.active_q = active_now;
		if (fp_starts_at_boundary) begin
			next_state.boundary = aligned_edge & active_now & ~state.active_q;
		end else begin
			next_state.boundary = aligned_edge & active_now & state.active_q;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign frame_boundary     = state.boundary;
	assign frame_pulse_active = state.active_q;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_pulse_polarity;
		!$past(reset) |-> frame_pulse_active
			== $past(fp_active_high ? input_frame_pulse : ~input_frame_pulse);
	endproperty
	a_pulse_polarity: assert property (p_pulse_polarity) else $error("frame pulse polarity wrong");

	property p_boundary_on_edge;
		frame_boundary |-> ($past(rising_edge_aligned) ? $rose(state.clock_q) : $fell(state.clock_q));
	endproperty
	a_boundary_on_edge: assert property (p_boundary_on_edge) else $error("boundary off aligned edge");

	property p_boundary_position;
		frame_boundary |-> frame_pulse_active && ($past(fp_starts_at_boundary) != $past(state.active_q));
	endproperty
	a_boundary_position: assert property (p_boundary_position) else $error("boundary position wrong");

endmodule : frame_boundary_detect

`default_nettype wire

// >>> design/switch_timing_control.sv
// Summary of operation
// - slave loop off while enable bit clear
// - slave loop on with enable and oscillator
// - slave loop on: low outputs from input timing
// - running loop keeps failure outputs driven
// - bits 12-11 pick master or slave
// - loopback clear: timing from external pins
// - loopback set in master mode: internal clock and frame used
// - position bit: straddle or start at boundary
// - polarity bit: falling or rising edge aligned
// - polarity bit: frame pulse low or high
// - rate field selects clock and pulse width; code decodes only the pulse width, no clock
`timescale 1ns/1ps
`default_nettype none

module switch_timing_control #(
	parameter int ADDR_WIDTH = 14
) (
	input  wire logic                             clk,
	input  wire logic                             reset,
	input  wire logic                             cpu_select,
	input  wire logic                             cpu_write,
	input  wire logic                             cpu_read,
	input  wire logic [ADDR_WIDTH-1:0]            cpu_address,
	input  wire logic [15:0]                      cpu_write_data,
	output logic      [15:0]                      cpu_read_data,
	output logic                                  cpu_read_valid,
	input  wire logic                             oscillator_enable,
	input  wire logic                             input_clock,
	input  wire logic                             input_frame_pulse,
	input  wire logic                             loopback_source_clock,
	input  wire logic                             loopback_source_frame,
	output switch_timing_pkg::timing_config_t     timing_config,
	output logic                                  selected_clock,
	output logic                                  selected_frame,
	output logic                                  frame_boundary,
	output logic                                  frame_pulse_active,
	output logic                                  frame_width_short
);

	// ==========================================================
	// parameter check
	if (ADDR_WIDTH < 14) begin : g_bad_width
		$error("ADDR_WIDTH must cover the register address");
	end

	// system clock must run at least twice the sampled timing clock
	if (switch_timing_pkg::LOOPBACK_CLOCK_KHZ * 2 > switch_timing_pkg::CLOCK_MHZ * 1000) begin : g_bad_clock
		$error("system clock too slow for the timing clock");
	end

	// widest frame pulse must fit the width counter
	if ((switch_timing_pkg::FP_WIDTH_4M_NS * switch_timing_pkg::CLOCK_MHZ + 999) / 1000 > 15) begin : g_bad_count
		$error("frame pulse width overflows the counter");
	end

	typedef struct packed {
		logic [15:0]                       ctrl;
		switch_timing_pkg::timing_config_t cfg;
		logic                              sel_clock;
		logic                              sel_frame;
		logic [15:0]                       rdata;
		logic                              rvalid;
		logic [3:0]                        width_count;
		logic                              width_short;
	} main_state_t;

	main_state_t state;
	main_state_t next_state;
	logic        hit;
	logic [15:0] c;
	logic        slave;
	logic        loop_on;

	// ==========================================================
	// register access and configuration decode
	always_comb begin
		next_state = state;
		hit = cpu_select && (cpu_address == ADDR_WIDTH'(switch_timing_pkg::MAIN_CONTROL_ADDR));
		if (hit && cpu_write) begin
			next_state.ctrl = cpu_write_data & switch_timing_pkg::MAIN_CONTROL_MASK;
		end
		next_state.rvalid = cpu_select && cpu_read;
		if (cpu_select && cpu_read) begin
			next_state.rdata = hit ? state.ctrl : 16'h0000;
		end
		c = next_state.ctrl;
		slave = c[switch_timing_pkg::OPERATION_HI:switch_timing_pkg::OPERATION_LO]
			!= switch_timing_pkg::OPERATION_MASTER;
		loop_on = slave ? (c[switch_timing_pkg::SLAVE_LOOP_ENABLE_BIT] & oscillator_enable) : oscillator_enable;
		next_state.cfg.slave_mode  = slave;
		next_state.cfg.loop_enable = loop_on;
		next_state.cfg.low_from_input  = slave & loop_on;
		next_state.cfg.high_locked_ref = loop_on;
		next_state.cfg.ref_fail_drive = loop_on;
		next_state.cfg.loopback_active       = ~slave & c[switch_timing_pkg::LOOPBACK_BIT];
		next_state.cfg.fp_starts_at_boundary = c[switch_timing_pkg::FP_POSITION_BIT];
		next_state.cfg.rising_edge_aligned   = c[switch_timing_pkg::CLOCK_POLARITY_BIT];
		next_state.cfg.fp_active_high        = c[switch_timing_pkg::FP_POLARITY_BIT];
		next_state.cfg.rate          = c[switch_timing_pkg::RATE_HI:switch_timing_pkg::RATE_LO];
		next_state.cfg.rate_reserved = next_state.cfg.rate == switch_timing_pkg::RATE_RESERVED;
		case (next_state.cfg.rate)
			switch_timing_pkg::RATE_16M: next_state.cfg.fp_width_cycles = switch_timing_pkg::FP_WIDTH_16M_CYCLES;
			switch_timing_pkg::RATE_8M:  next_state.cfg.fp_width_cycles = switch_timing_pkg::FP_WIDTH_8M_CYCLES;
			switch_timing_pkg::RATE_4M:  next_state.cfg.fp_width_cycles = switch_timing_pkg::FP_WIDTH_4M_CYCLES;
			default:                     next_state.cfg.fp_width_cycles = 4'h0;
		endcase
		next_state.cfg.loopback_rate_conflict = next_state.cfg.loopback_active
			&& (next_state.cfg.rate != switch_timing_pkg::RATE_16M);
		if (state.cfg.loopback_active) begin
			next_state.sel_clock = loopback_source_clock;
			next_state.sel_frame = loopback_source_frame;
		end else begin
			next_state.sel_clock = input_clock;
			next_state.sel_frame = input_frame_pulse;
		end
		if (frame_pulse_active) begin
			if (state.width_count != 4'hF) begin
				next_state.width_count = state.width_count + 4'h1;
			end
		end else begin
			next_state.width_count = 4'h0;
			if (state.width_count != 4'h0) begin
				next_state.width_short = state.width_count < state.cfg.fp_width_cycles;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// ==========================================================
	// frame boundary extraction
	frame_boundary_detect u_detect (
		.clk                   (clk),
		.reset                 (reset),
		.input_clock           (state.sel_clock),
		.input_frame_pulse     (state.sel_frame),
		.rising_edge_aligned   (state.cfg.rising_edge_aligned),
		.fp_active_high        (state.cfg.fp_active_high),
		.fp_starts_at_boundary (state.cfg.fp_starts_at_boundary),
		.frame_boundary        (frame_boundary),
		.frame_pulse_active    (frame_pulse_active)
	);

	assign cpu_read_data     = state.rdata;
	assign cpu_read_valid    = state.rvalid;
	assign timing_config     = state.cfg;
	assign selected_clock    = state.sel_clock;
	assign selected_frame    = state.sel_frame;
	assign frame_width_short = state.width_short;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_slave_loop_off;
		(timing_config.slave_mode && !state.ctrl[switch_timing_pkg::SLAVE_LOOP_ENABLE_BIT])
			|-> !timing_config.loop_enable;
	endproperty
	a_slave_loop_off: assert property (p_slave_loop_off) else $error("slave loop on without enable");

	property p_slave_loop_on;
		timing_config.slave_mode |-> timing_config.loop_enable
			== (state.ctrl[switch_timing_pkg::SLAVE_LOOP_ENABLE_BIT] && $past(oscillator_enable));
	endproperty
	a_slave_loop_on: assert property (p_slave_loop_on) else $error("slave loop enable mismatch");

	property p_output_sources;
		timing_config.low_from_input == (timing_config.slave_mode && timing_config.loop_enable)
			&& timing_config.high_locked_ref == timing_config.loop_enable;
	endproperty
	a_output_sources: assert property (p_output_sources) else $error("output clock source wrong");

	property p_fail_drive;
		timing_config.ref_fail_drive == timing_config.loop_enable;
	endproperty
	a_fail_drive: assert property (p_fail_drive) else $error("failure outputs not driven");

	property p_mode_write;
		(hit && cpu_write) |=> timing_config.slave_mode
			== ($past(cpu_write_data[12:11]) != switch_timing_pkg::OPERATION_MASTER);
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("mode not taken from write");

	property p_external_source;
		!timing_config.loopback_active |=> selected_clock == $past(input_clock)
			&& selected_frame == $past(input_frame_pulse);
	endproperty
	a_external_source: assert property (p_external_source) else $error("pins not used");

	property p_loopback_source;
		timing_config.loopback_active |=> selected_clock == $past(loopback_source_clock)
			&& selected_frame == $past(loopback_source_frame);
	endproperty
	a_loopback_source: assert property (p_loopback_source) else $error("loopback source not used");

	property p_rate_conflict;
		timing_config.loopback_rate_conflict
			== (timing_config.loopback_active && timing_config.rate != switch_timing_pkg::RATE_16M);
	endproperty
	a_rate_conflict: assert property (p_rate_conflict) else $error("loopback rate flag wrong");

	property p_rate_width;
		timing_config.rate == switch_timing_pkg::RATE_8M |-> timing_config.fp_width_cycles == 4'h5;
	endproperty
	a_rate_width: assert property (p_rate_width) else $error("rate width decode wrong");

	property p_read_back;
		(hit && cpu_read && !cpu_write) |=> cpu_read_valid && cpu_read_data == $past(state.ctrl)
			&& cpu_read_data[15:14] == 2'h0;
	endproperty
	a_read_back: assert property (p_read_back) else $error("read value wrong");

	property p_reset_clear;
		$past(reset) |-> state.ctrl == switch_timing_pkg::MAIN_CONTROL_RESET;
	endproperty
	a_reset_clear: assert property (@(posedge clk) p_reset_clear) else $error("reset left bits set");

	property p_master_loop;
		!$past(reset) && !timing_config.slave_mode
			|-> timing_config.loop_enable == $past(oscillator_enable);
	endproperty
	a_master_loop: assert property (p_master_loop) else $error("master loop not following oscillator");

	property p_slave_no_loopback;
		timing_config.slave_mode |-> !timing_config.loopback_active;
	endproperty
	a_slave_no_loopback: assert property (p_slave_no_loopback) else $error("loopback used in slave");

	property p_write_stores;
		(hit && cpu_write) |=> state.ctrl
			== ($past(cpu_write_data) & switch_timing_pkg::MAIN_CONTROL_MASK);
	endproperty
	a_write_stores: assert property (p_write_stores) else $error("write not stored");

	property p_unmapped_write;
		(cpu_select && cpu_write && !hit) |=> $stable(state.ctrl);
	endproperty
	a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write stored");

	property p_unmapped_read;
		(cpu_select && cpu_read && !hit) |=> cpu_read_valid && cpu_read_data == 16'h0000;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

	property p_read_valid_pulse;
		!(cpu_select && cpu_read) |=> !cpu_read_valid;
	endproperty
	a_read_valid_pulse: assert property (p_read_valid_pulse) else $error("read valid without read");

	property p_polarity_fields;
		timing_config.fp_starts_at_boundary == state.ctrl[switch_timing_pkg::FP_POSITION_BIT]
			&& timing_config.rising_edge_aligned == state.ctrl[switch_timing_pkg::CLOCK_POLARITY_BIT]
			&& timing_config.fp_active_high == state.ctrl[switch_timing_pkg::FP_POLARITY_BIT];
	endproperty
	a_polarity_fields: assert property (p_polarity_fields) else $error("timing fields not decoded");

	property p_rate_width_16m;
		!$past(reset) && timing_config.rate == switch_timing_pkg::RATE_16M
			|-> timing_config.fp_width_cycles == 4'h3;
	endproperty
	a_rate_width_16m: assert property (p_rate_width_16m) else $error("16M width decode wrong");

	property p_rate_width_4m;
		timing_config.rate == switch_timing_pkg::RATE_4M |-> timing_config.fp_width_cycles == 4'hA;
	endproperty
	a_rate_width_4m: assert property (p_rate_width_4m) else $error("4M width decode wrong");

	property p_rate_reserved;
		timing_config.rate_reserved |-> timing_config.rate == switch_timing_pkg::RATE_RESERVED
			&& timing_config.fp_width_cycles == 4'h0;
	endproperty
	a_rate_reserved: assert property (p_rate_reserved) else $error("reserved rate decode wrong");

	property p_width_short;
		(!frame_pulse_active && state.width_count != 4'h0) |=> frame_width_short
			== ($past(state.width_count) < $past(timing_config.fp_width_cycles));
	endproperty
	a_width_short: assert property (p_width_short) else $error("pulse width flag wrong");

	property p_width_clear;
		!frame_pulse_active |=> state.width_count == 4'h0;
	endproperty
	a_width_clear: assert property (p_width_clear) else $error("width count not cleared");

endmodule : switch_timing_control

`default_nettype wire

// >>> tb/backplane_timing_source.sv
`timescale 1ns/1ps
`default_nettype none

module backplane_timing_source (
	input  wire logic       clk,
	input  wire logic       aligned_rising,
	input  wire logic       starts_at_boundary,
	input  wire logic       active_high,
	input  wire logic       loop_mode,
	output logic      [4:0] frame_phase,
	output logic            input_clock,
	output logic            input_frame_pulse,
	output logic            loopback_source_clock,
	output logic            loopback_source_frame
);
	// ==========================================================
	// frame of 32 system cycles, timing clock toggles every 2
	logic ck;
	logic active;
	logic fp;

	logic [4:0] phase = 5'h00;

	always @(negedge clk) begin
		phase <= phase + 5'h01;
	end

	assign frame_phase = phase;

	always_comb begin
		ck = frame_phase[1] ^ aligned_rising;
		if (starts_at_boundary)
			active = (frame_phase < 5'h04);
		else
			active = (frame_phase >= 5'h1E) || (frame_phase < 5'h02);
		fp = active ? active_high : ~active_high;
		input_clock           = loop_mode ? 1'b1 : ck;
		input_frame_pulse     = loop_mode ? 1'b1 : fp;
		// unused loopback source toggles, unused pins held high, so a wrong selection shows up
		loopback_source_clock = loop_mode ? ck : frame_phase[0];
		loopback_source_frame = loop_mode ? fp : ~frame_phase[0];
	end
endmodule : backplane_timing_source

`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHECK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
	$display("ERROR %s expected %h seen %h", nm, e, a); end end

module tb_top;
	logic                               clk;
	logic                               reset;
	logic                               sel;
	logic                               wr;
	logic                               rd;
	logic [13:0]                        addr;
	logic [15:0]                        wdata;
	logic [15:0]                        cpu_read_data;
	logic                               cpu_read_valid;
	logic                               osc;
	logic                               in_ck;
	logic                               in_fp;
	logic                               lb_ck;
	logic                               lb_fp;
	switch_timing_pkg::timing_config_t  timing_config;
	logic                               frame_boundary;
	logic [4:0]                         frame_phase;
	logic                               width_short;
	logic                               pt_rising;
	logic                               pt_start;
	logic                               pt_high;
	logic                               pt_loop;
	logic [15:0]                        exp_q[$];
	logic [15:0]                        exp_v;
	logic [15:0]                        v;
	logic [8:0]                         nb;
	int                                 error_cnt;
	int                                 cmp_count;
	int                                 seed;

	switch_timing_control #(.ADDR_WIDTH(14)) DUT (
		.clk(clk), .reset(reset), .cpu_select(sel), .cpu_write(wr), .cpu_read(rd),
		.cpu_address(addr), .cpu_write_data(wdata), .cpu_read_data(cpu_read_data),
		.cpu_read_valid(cpu_read_valid), .oscillator_enable(osc), .input_clock(in_ck),
		.input_frame_pulse(in_fp), .loopback_source_clock(lb_ck), .loopback_source_frame(lb_fp),
		.timing_config(timing_config), .selected_clock(), .selected_frame(),
		.frame_boundary(frame_boundary), .frame_pulse_active(), .frame_width_short(width_short)
	);

	backplane_timing_source partner (
		.clk(clk), .aligned_rising(pt_rising), .starts_at_boundary(pt_start),
		.active_high(pt_high), .loop_mode(pt_loop), .frame_phase(frame_phase),
		.input_clock(in_ck), .input_frame_pulse(in_fp),
		.loopback_source_clock(lb_ck), .loopback_source_frame(lb_fp)
	);

	// ==========================================================
	// clock, monitor, watchdog
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(negedge clk) begin
		if (cpu_read_valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				error_cnt++;
				$display("ERROR cpu_read_valid expected 0 seen 1");
			end else begin
				exp_v = exp_q.pop_front();
				`CHECK("cpu_read_data", exp_v, cpu_read_data)
			end
		end
	end

	initial begin
		#600000;
		error_cnt++;
		final_report();
	end

	// ==========================================================
	// expected decode of the control word
	function automatic switch_timing_pkg::timing_config_t exp_cfg(input logic [15:0] w, input logic o);
		switch_timing_pkg::timing_config_t c;
		c = '0;
		c.slave_mode             = (w[12:11] != 2'h0);
		c.loop_enable            = c.slave_mode ? (w[13] & o) : o;
		c.low_from_input         = c.slave_mode & c.loop_enable;
		c.high_locked_ref        = c.loop_enable;
		c.ref_fail_drive         = c.loop_enable;
		c.loopback_active        = w[10] & ~c.slave_mode;
		c.fp_starts_at_boundary  = w[9];
		c.rising_edge_aligned    = w[8];
		c.fp_active_high         = w[7];
		c.rate                   = w[6:5];
		c.rate_reserved          = (w[6:5] == 2'h3);
		c.loopback_rate_conflict = c.loopback_active & (w[6:5] != 2'h0);
		case (w[6:5])
			2'h0: c.fp_width_cycles = switch_timing_pkg::FP_WIDTH_16M_CYCLES;
			2'h1: c.fp_width_cycles = switch_timing_pkg::FP_WIDTH_8M_CYCLES;
			2'h2: c.fp_width_cycles = switch_timing_pkg::FP_WIDTH_4M_CYCLES;
			default: c.fp_width_cycles = 4'h0;
		endcase
		return c;
	endfunction : exp_cfg

	// ==========================================================
	// register bus
	task automatic bus_write(input logic [13:0] a, input logic [15:0] d);
		@(negedge clk);
		sel = 1'b1; wr = 1'b1; addr = a; wdata = d;
		@(negedge clk);
		sel = 1'b0; wr = 1'b0;
	endtask : bus_write

	task automatic bus_read(input logic [13:0] a, input logic [15:0] e);
		@(negedge clk);
		sel = 1'b1; rd = 1'b1; addr = a;
		exp_q.push_back(e);
		@(negedge clk);
		sel = 1'b0; rd = 1'b0;
	endtask : bus_read

	task automatic final_report();
		if (exp_q.size() != 0) error_cnt++;
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : final_report

	// ==========================================================
	// main sequence
	initial begin
		seed = 39;
		error_cnt = 0; cmp_count = 0;
		reset = 1'b1; sel = 1'b0; wr = 1'b0; rd = 1'b0; addr = 14'h0000; wdata = 16'h0000;
		osc = 1'b1; pt_rising = 1'b0; pt_start = 1'b0; pt_high = 1'b0; pt_loop = 1'b0;
		repeat (16) @(negedge clk);
		reset = 1'b0;
		@(negedge clk);
		`CHECK("timing_config", exp_cfg(16'h0000, osc), timing_config)
		bus_read(14'h0000, 16'h0000);
		$display("test reset values done");

		for (int i = 0; i < 64; i++) begin
			v = 16'($random(seed));
			v[13:11] = i[2:0];
			v[6:5] = i[4:3];
			if (i != 5) v[15:14] = 2'h0;
			osc = i[5];
			bus_write(14'h0000, v);
			@(negedge clk);
			`CHECK("timing_config", exp_cfg(v, osc), timing_config)
			bus_read(14'h0000, v & 16'h3FFF);
		end
		bus_write(14'h0001, 16'hFFFF);
		bus_read(14'h0001, 16'h0000);
		bus_read(14'h0000, v & 16'h3FFF);
		$display("test register sweep done");

		for (int k = 0; k < 6; k++) begin
			v = 16'h0000;
			v[8] = k[0];
			v[9] = k[1];
			v[7] = k[0] ^ k[1];
			if (k >= 4) v[10] = 1'b1;
			if (k == 5) v[12:11] = 2'h1;
			v[5] = k[0] & ~k[2];
			pt_rising = v[8]; pt_start = v[9]; pt_high = v[7]; pt_loop = (k == 4);
			bus_write(14'h0000, v);
			repeat (40) @(negedge clk);
			while (frame_phase != 5'h10) @(posedge clk);
			nb = 9'h000;
			repeat (256) begin
				@(negedge clk);
				if (frame_boundary === 1'b1) nb++;
			end
			`CHECK("frame_boundary count", 9'h008, nb)
			`CHECK("frame_width_short", k[0] & ~k[2], width_short)
		end
		$display("test frame timing done");

		bus_write(14'h0000, 16'h3FFF);
		@(negedge clk);
		reset = 1'b1;
		repeat (2) @(negedge clk);
		reset = 1'b0;
		@(negedge clk);
		`CHECK("timing_config", exp_cfg(16'h0000, osc), timing_config)
		bus_read(14'h0000, 16'h0000);
		repeat (3) @(negedge clk);
		$display("test second reset done");
		final_report();
	end
endmodule : tb_top

`default_nettype wire
